// ===== rtl/ctpm_core.sv
// Purpose: counter for period, pulse width, semiperiod, two-edge
//          separation and encoder position, with AXI4-Lite registers
// Assumes: all pins asynchronous to aclk; paired counter on aclk
// Notes:   results leave on a valid/ready sample stream
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module ctpm_core (
	// clock and reset
	input  logic                      aclk,
	input  logic                      aresetn,
	// axi4-lite write address and data
	input  logic [ctpm_pkg::AW-1:0]   s_axi_awaddr,
	input  logic                      s_axi_awvalid,
	output logic                      s_axi_awready,
	input  logic [31:0]               s_axi_wdata,
	input  logic [3:0]                s_axi_wstrb,
	input  logic                      s_axi_wvalid,
	output logic                      s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  logic                      s_axi_bready,
	// axi4-lite read
	input  logic [ctpm_pkg::AW-1:0]   s_axi_araddr,
	input  logic                      s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  logic                      s_axi_rready,
	// measured pins
	input  logic                      sig_a,
	input  logic                      sig_b,
	input  logic                      sig_z,
	input  logic                      samp_clk,
	// paired counter route
	input  logic                      pair_in,
	output logic                      pair_out,
	// sample stream
	output logic                      smp_valid,
	input  logic                      smp_ready,
	output ctpm_pkg::ctpm_smp_s       smp
);
	ctpm_pkg::ctpm_st_s   q;
	ctpm_pkg::ctpm_st_s   d;
	ctpm_pkg::ctpm_mode_e mode;
	ctpm_pkg::ctpm_mode_e wmode;
	ctpm_pkg::ctpm_dec_e  dec;
	logic [ctpm_pkg::ACC_W-1:0] rate;
	logic [ctpm_pkg::ACC_W-1:0] acc_sum;
	logic [ctpm_pkg::CW-1:0]    ev;
	logic [3:0]  pins;
	logic [3:0]  nx;
	logic [3:0]  rise;
	logic [3:0]  fall;
	logic [31:0] cur;
	logic [31:0] wv;
	logic [31:0] rd;
	logic        tick;
	logic        armed;
	logic        arm_go;
	logic        dis_go;
	logic        ar;
	logic        af;
	logic        e1;
	logic        e1n;
	logic        e2;
	logic        ach;
	logic        bch;
	logic        xo;
	logic        up;
	logic        dn;
	logic        idx_hit;
	logic        emit;
	logic        ehi;
	logic        free;

	assign pins = {samp_clk, sig_z, sig_b, sig_a};

	// bus handshakes come straight from state
	assign s_axi_awready = !q.aw_got && !q.bvalid;
	assign s_axi_wready  = !q.w_got && !q.bvalid;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
	assign smp_valid     = q.smp_valid;
	assign smp           = q.smp;
	assign pair_out      = q.st[0];

	// next-state logic for the whole block
	always_comb begin
		d       = q;
		arm_go  = 1'b0;
		dis_go  = 1'b0;
		emit    = 1'b0;
		ehi     = 1'b0;
		ev      = '0;
		up      = 1'b0;
		dn      = 1'b0;
		cur     = '0;
		rd      = '0;
		armed   = q.ctrl[ctpm_pkg::C_ARM];
		mode    = ctpm_pkg::ctpm_mode_e'(q.ctrl[ctpm_pkg::C_MODE +: 3]);
		dec     = ctpm_pkg::ctpm_dec_e'(q.ctrl[ctpm_pkg::C_DEC +: 2]);

		// fractional divider: 4 of 5 cycles or 1 of 250 cycles
		rate    = q.ctrl[ctpm_pkg::C_TB] ? ctpm_pkg::ACC_SLOW : ctpm_pkg::ACC_FAST;
		acc_sum = q.acc + rate;
		tick    = acc_sum >= ctpm_pkg::ACC_MOD;
		d.acc   = tick ? acc_sum - ctpm_pkg::ACC_MOD : acc_sum;

		// three-stage sync; a change counts once stages 2 and 3 agree
		d.sy = {q.sy[1], q.sy[0], pins};
		for (int i = 0; i < 4; i++) begin
			nx[i] = (q.sy[1][i] == q.sy[2][i]) ? q.sy[1][i] : q.st[i];
		end
		d.st = nx;
		rise = nx & ~q.st;
		fall = ~nx & q.st;

		// paired counter may stand in for input A
		d.pair_prev = pair_in;
		ar  = q.ctrl[ctpm_pkg::C_PAIR] ? (pair_in & ~q.pair_prev) : rise[0];
		af  = q.ctrl[ctpm_pkg::C_PAIR] ? (~pair_in & q.pair_prev) : fall[0];
		e1  = q.ctrl[ctpm_pkg::C_POL] ? af : ar;
		e1n = q.ctrl[ctpm_pkg::C_POL] ? ar : af;
		e2  = q.ctrl[ctpm_pkg::C_POL2] ? fall[1] : rise[1];

		// quadrature decode from stable phases
		ach = rise[0] | fall[0];
		bch = rise[1] | fall[1];
		xo  = nx[0] ^ nx[1];
		unique case (dec)
			ctpm_pkg::D_X1: begin
				up = ach & ~nx[1] & nx[0];
				dn = ach & ~nx[1] & ~nx[0];
			end
			ctpm_pkg::D_X2: begin
				up = ach & xo;
				dn = ach & ~xo;
			end
			ctpm_pkg::D_X4: begin
				up = (ach & ~bch & xo) | (bch & ~ach & ~xo);
				dn = (ach & ~bch & ~xo) | (bch & ~ach & xo);
			end
			ctpm_pkg::D_TWO_PULSE: begin
				up = rise[0] & ~rise[1];
				dn = rise[1] & ~rise[0];
			end
		endcase
		idx_hit = q.ctrl[ctpm_pkg::C_IDX] & nx[2]
			& (nx[1:0] == q.ctrl[ctpm_pkg::C_PH +: 2]);

		// stream drain; a held sample blocks new ones
		if (q.smp_valid && smp_ready) begin
			d.smp_valid = 1'b0;
		end
		free = !q.smp_valid || smp_ready;

		// write channels are taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_got  = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_got  = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		case (q.aw_addr)
			ctpm_pkg::A_CTRL: cur = q.ctrl;
			ctpm_pkg::A_INIT: cur = q.init_pos;
			ctpm_pkg::A_RLD:  cur = q.reload;
			default:          cur = '0;
		endcase
		wv = cur;
		for (int i = 0; i < 4; i++) begin
			if (q.w_strb[i]) begin
				wv[8*i +: 8] = q.w_data[8*i +: 8];
			end
		end
		wmode = ctpm_pkg::ctpm_mode_e'(wv[ctpm_pkg::C_MODE +: 3]);
		if (q.aw_got && q.w_got) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = ctpm_pkg::R_OK;
			case (q.aw_addr)
				ctpm_pkg::A_CTRL: begin
					d.ctrl = wv;
					arm_go = wv[ctpm_pkg::C_ARM] & ~q.ctrl[ctpm_pkg::C_ARM];
					dis_go = ~wv[ctpm_pkg::C_ARM];
				end
				ctpm_pkg::A_INIT: d.init_pos = wv;
				ctpm_pkg::A_RLD:  d.reload = wv;
				ctpm_pkg::A_STAT: begin
					// write one to clear; a same-cycle event still sets
					d.res_val  = q.res_val & ~wv[ctpm_pkg::S_RES];
					d.roll_res = q.roll_res & ~wv[ctpm_pkg::S_ROLL];
					d.ovr      = q.ovr & ~wv[ctpm_pkg::S_OVR];
				end
				ctpm_pkg::A_RES, ctpm_pkg::A_POS: ;
				default: d.bresp = ctpm_pkg::R_ERR;
			endcase
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end

		// read: answer registered one cycle after the address
		rd[ctpm_pkg::S_ARM]  = armed;
		rd[ctpm_pkg::S_RES]  = q.res_val;
		rd[ctpm_pkg::S_ROLL] = q.roll_res;
		rd[ctpm_pkg::S_SEMI] = q.semi_hi;
		rd[ctpm_pkg::S_OVR]  = q.ovr;
		rd[ctpm_pkg::S_SMP]  = q.smp_valid;
		if (s_axi_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rresp  = ctpm_pkg::R_OK;
			case (s_axi_araddr)
				ctpm_pkg::A_CTRL: d.rdata = q.ctrl;
				ctpm_pkg::A_STAT: d.rdata = rd;
				ctpm_pkg::A_INIT: d.rdata = q.init_pos;
				ctpm_pkg::A_RLD:  d.rdata = q.reload;
				ctpm_pkg::A_RES: begin
					d.rdata   = q.result;
					d.res_val = 1'b0;
				end
				ctpm_pkg::A_POS: begin
					if (armed) begin
						d.rdata = q.pos;
					end else begin
						// implicit arm and disarm: nothing kept between reads
						d.rdata = q.init_pos;
						d.pos   = q.init_pos;
					end
				end
				default: begin
					d.rdata = '0;
					d.rresp = ctpm_pkg::R_ERR;
				end
			endcase
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end

		// tick counter with rollover memory
		if (armed && q.running && tick) begin
			d.cnt = q.cnt + 1'b1;
			if (&q.cnt) begin
				d.roll_run = 1'b1;
			end
		end

		// measurement modes; only one counter in use by default
		if (armed) begin
			unique case (mode)
				ctpm_pkg::M_PERIOD: begin
					if (e1) begin
						emit  = 1'b1;
						ev    = q.cnt;
						d.cnt = '0;
					end
				end
				ctpm_pkg::M_PULSE: begin
					if (e1) begin
						d.cnt      = '0;
						d.running  = 1'b1;
						d.roll_run = 1'b0;
					end else if (e1n && q.running) begin
						emit      = 1'b1;
						ev        = q.cnt;
						d.running = 1'b0;
					end
				end
				ctpm_pkg::M_SEMI: begin
					if (ar || af) begin
						emit      = 1'b1;
						ev        = q.cnt;
						ehi       = af;
						d.semi_hi = af;
						d.cnt     = '0;
					end
				end
				ctpm_pkg::M_TWO_EDGE: begin
					if (e1) begin
						d.cnt      = '0;
						d.running  = 1'b1;
						d.roll_run = 1'b0;
					end else if (e2 && q.running) begin
						emit      = 1'b1;
						ev        = q.cnt;
						d.running = 1'b0;
					end
				end
				ctpm_pkg::M_POSITION: begin
					if (idx_hit) begin
						d.pos = q.reload;
					end else if (up) begin
						d.pos = q.pos + 1'b1;
					end else if (dn) begin
						d.pos = q.pos - 1'b1;
					end
					if (q.ctrl[ctpm_pkg::C_BUF] && rise[3]) begin
						emit = 1'b1;
						ev   = q.pos;
					end
				end
				default: ;
			endcase
		end

		// result capture; a full stream drops the sample and flags it
		if (emit) begin
			d.result   = ev;
			d.res_val  = 1'b1;
			d.roll_res = d.roll_run;
			d.roll_run = 1'b0;
			if (free) begin
				d.smp_valid    = 1'b1;
				d.smp.data     = ev;
				d.smp.roll     = d.roll_res;
				d.smp.semi_hi  = ehi;
			end else begin
				d.ovr = 1'b1;
			end
		end

		// arming presets; time modes but two-edge start at once
		if (arm_go) begin
			d.pos      = q.init_pos;
			d.cnt      = '0;
			d.roll_run = 1'b0;
			d.running  = (wmode == ctpm_pkg::M_PERIOD) || (wmode == ctpm_pkg::M_PULSE)
				|| (wmode == ctpm_pkg::M_SEMI);
		end else if (dis_go) begin
			d.running = 1'b0;
		end
	end

	// single state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= ctpm_pkg::ST_RST;
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_per_edge;
		armed && mode == ctpm_pkg::M_PERIOD && e1 && !arm_go;
	endsequence
	sequence s_pw_open;
		armed && mode == ctpm_pkg::M_PULSE && e1 && !arm_go && !dis_go;
	endsequence
	sequence s_pw_close;
		armed && mode == ctpm_pkg::M_PULSE && !e1 && e1n && q.running && !arm_go;
	endsequence
	sequence s_te_stop;
		armed && mode == ctpm_pkg::M_TWO_EDGE && !e1 && e2 && q.running && !arm_go;
	endsequence

	a_period_count: assert property (
		s_per_edge |=> q.result == $past(q.cnt) && q.cnt == '0 && q.res_val)
		else $error("period result not latched");
	a_fast_tick: assert property (
		(!q.ctrl[ctpm_pkg::C_TB] && !tick) ##1 !q.ctrl[ctpm_pkg::C_TB] |-> tick)
		else $error("fast timebase missed a tick");
	a_slow_tick: assert property (
		q.ctrl[ctpm_pkg::C_TB] && tick |=> !tick)
		else $error("slow timebase ticked too often");
	a_arm_start: assert property (
		arm_go && wmode == ctpm_pkg::M_PERIOD |=> q.running && q.cnt == '0)
		else $error("period count did not start at arm");
	a_arm_preset: assert property (
		arm_go |=> q.pos == $past(q.init_pos))
		else $error("position not preset at arm");
	a_idx_reload: assert property (
		armed && mode == ctpm_pkg::M_POSITION && idx_hit && !arm_go
		|=> q.pos == $past(q.reload))
		else $error("index did not reload position");
	a_quad_step: assert property (
		armed && mode == ctpm_pkg::M_POSITION && up && !idx_hit && !arm_go
		|=> q.pos == $past(q.pos) + 1'b1)
		else $error("position did not step up");
	a_pos_keep: assert property (
		s_axi_arvalid && !q.rvalid && s_axi_araddr == ctpm_pkg::A_POS && armed
		|=> q.rdata == $past(q.pos) && q.rvalid)
		else $error("armed position read wrong");
	a_implicit_arm: assert property (
		s_axi_arvalid && !q.rvalid && s_axi_araddr == ctpm_pkg::A_POS && !armed && !arm_go
		|=> q.rdata == $past(q.init_pos) && q.pos == $past(q.init_pos))
		else $error("unarmed read kept position");
	a_buf_latch: assert property (
		armed && mode == ctpm_pkg::M_POSITION && q.ctrl[ctpm_pkg::C_BUF] && rise[3] && free
		|=> q.smp_valid && q.smp.data == $past(q.pos))
		else $error("sample clock did not latch position");
	a_pulse_width: assert property (
		s_pw_close |=> q.result == $past(q.cnt) && !q.running && q.res_val)
		else $error("pulse width not reported");
	a_pulse_open: assert property (
		s_pw_open |=> q.running && q.cnt == '0)
		else $error("pulse width did not restart");
	a_semi_edge: assert property (
		armed && mode == ctpm_pkg::M_SEMI && (ar || af) && !arm_go
		|=> q.res_val && q.semi_hi == $past(af) && q.result == $past(q.cnt))
		else $error("semiperiod edge gave no result");
	a_two_edge: assert property (
		s_te_stop |=> q.result == $past(q.cnt) && !q.running)
		else $error("two-edge result wrong");
	a_sync_path: assert property (
		q.st[0] != $past(q.st[0])
		|-> $past(q.sy[1][0]) == q.st[0] && $past(q.sy[2][0]) == q.st[0])
		else $error("edge taken before stages agreed");
	a_roll_mark: assert property (
		armed && mode == ctpm_pkg::M_PERIOD && q.running && tick && (&q.cnt) && !e1 && !arm_go
		|=> q.roll_run)
		else $error("rollover not recorded");
endmodule : ctpm_core

// ===== rtl/ctpm_pkg.sv
// Purpose: shared constants and types for the time and position counter
// Assumes: 25 MHz core clock, registers reached over AXI4-Lite
// Notes:   counter width is fixed here so every user sees the same value
package ctpm_pkg;
	// core clock and timebase rates in hertz
	localparam int CLK_HZ  = 25_000_000;
	localparam int FAST_HZ = 20_000_000;
	localparam int SLOW_HZ = 100_000;
	localparam int ACC_W   = 26;
	localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(CLK_HZ);
	localparam logic [ACC_W-1:0] ACC_FAST = ACC_W'(FAST_HZ);
	localparam logic [ACC_W-1:0] ACC_SLOW = ACC_W'(SLOW_HZ);
	// measurement counter width
	localparam int CW = 32;
	// register byte offsets
	localparam int AW = 8;
	localparam logic [AW-1:0] A_CTRL = 8'h00;
	localparam logic [AW-1:0] A_STAT = 8'h04;
	localparam logic [AW-1:0] A_INIT = 8'h08;
	localparam logic [AW-1:0] A_RLD  = 8'h0C;
	localparam logic [AW-1:0] A_RES  = 8'h10;
	localparam logic [AW-1:0] A_POS  = 8'h14;
	// control field positions
	localparam int C_ARM = 0, C_TB = 1, C_MODE = 2, C_POL = 5, C_POL2 = 6;
	localparam int C_IDX = 7, C_PH = 8, C_DEC = 10, C_PAIR = 12, C_BUF = 13;
	// status field positions
	localparam int S_ARM = 0, S_RES = 1, S_ROLL = 2, S_SEMI = 3, S_OVR = 4, S_SMP = 5;
	// bus responses
	localparam logic [1:0] R_OK  = 2'h0;
	localparam logic [1:0] R_ERR = 2'h2;
	typedef enum logic [2:0] {M_PERIOD, M_PULSE, M_SEMI, M_TWO_EDGE, M_POSITION} ctpm_mode_e;
	typedef enum logic [1:0] {D_X1, D_X2, D_X4, D_TWO_PULSE} ctpm_dec_e;
	// one result on the sample stream
	typedef struct packed {
		logic [CW-1:0] data;
		logic          roll;
		logic          semi_hi;
	} ctpm_smp_s;
	// whole state of the block
	typedef struct packed {
		logic            aw_got;
		logic [AW-1:0]   aw_addr;
		logic            w_got;
		logic [31:0]     w_data;
		logic [3:0]      w_strb;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            rvalid;
		logic [31:0]     rdata;
		logic [1:0]      rresp;
		logic [31:0]     ctrl;
		logic [CW-1:0]   init_pos;
		logic [CW-1:0]   reload;
		logic [CW-1:0]   result;
		logic [CW-1:0]   pos;
		logic [CW-1:0]   cnt;
		logic            running;
		logic            res_val;
		logic            roll_run;
		logic            roll_res;
		logic            semi_hi;
		logic            ovr;
		logic            smp_valid;
		ctpm_smp_s       smp;
		logic [ACC_W-1:0] acc;
		logic [2:0][3:0] sy;
		logic [3:0]      st;
		logic            pair_prev;
	} ctpm_st_s;
	localparam ctpm_st_s ST_RST = '0;
endpackage : ctpm_pkg

// ===== verification/ctpm_src.sv
// Purpose: pin source standing in for a pulse train or an encoder
// Assumes: every change lands just after a rising aclk edge
// Notes:   all pins are driven and rest low between bursts
`timescale 1ns/1ps
module ctpm_src (
	// clock
	input  logic aclk,
	// pins toward the counter
	output logic sig_a,
	output logic sig_b,
	output logic sig_z,
	output logic samp_clk,
	output logic pair_in
);
	// pins idle low from time zero
	initial begin
		{sig_a, sig_b, sig_z, samp_clk, pair_in} = 5'h00;
	end

	task automatic w(input int n);
		repeat (n) @(posedge aclk);
	endtask : w

	// square wave on A, or on the paired route
	task automatic sq(input int hi, input int lo, input int n, input bit p);
		repeat (n) begin
			if (p) pair_in <= 1'b1;
			else sig_a <= 1'b1;
			w(hi);
			if (p) pair_in <= 1'b0;
			else sig_a <= 1'b0;
			w(lo);
		end
	endtask : sq

	// one pulse on a chosen pin; the sample clock comes only from here
	task automatic pulse(input int k, input int h);
		for (int v = 1; v >= 0; v--) begin
			case (k)
				0: sig_a <= v[0];
				1: sig_b <= v[0];
				2: sig_z <= v[0];
				default: samp_clk <= v[0];
			endcase
			w(h);
		end
	endtask : pulse

	// gray steps, A leading B when fwd, so phases sit 90 degrees apart
	task automatic quad(input int n, input bit fwd, input int gap);
		logic [3:0][1:0] s;
		s = {2'h2, 2'h3, 2'h1, 2'h0};
		repeat (n) for (int i = 1; i <= 4; i++) begin
			{sig_b, sig_a} <= s[fwd ? i % 4 : (4 - i) % 4];
			w(gap);
		end
	endtask : quad

	// A rises, B rises 25 clocks later and falls 10 after that
	task automatic e2;
		sig_a <= 1'b1;
		w(25);
		sig_b <= 1'b1;
		w(10);
		{sig_a, sig_b} <= 2'h0;
		w(8);
	endtask : e2
endmodule : ctpm_src

// ===== verification/test_counter_time_and_position_measure.sv
// Purpose: self-checking bench for the time and position counter
// Assumes: 25 MHz aclk, 20 MHz timebase gives 0.8 ticks a clock
// Notes:   tick counts are allowed one tick of quantisation either way
`timescale 1ns/1ps
module test_counter_time_and_position_measure;
	logic                aclk    = 1'b0;
	logic                aresetn, awvalid, wvalid, bready, arvalid, rready, smp_ready;
	logic [7:0]          awaddr, araddr;
	logic [31:0]         wdata;
	logic [3:0]          wstrb;
	logic                awready, wready, bvalid, arready, rvalid, smp_valid, pair_out;
	logic                sig_a, sig_b, sig_z, samp_clk, pair_in;
	logic [1:0]          bresp, rresp, resp;
	logic [31:0]         rdata, rv;
	logic [3:0]          strb    = 4'hF;
	ctpm_pkg::ctpm_smp_s smp;
	ctpm_pkg::ctpm_smp_s q[$];
	int                  err_count  = 0;
	int                  num_checks = 0;
	localparam int ARM = 1 << ctpm_pkg::C_ARM, TB = 1 << ctpm_pkg::C_TB;
	localparam int IDX = 1 << ctpm_pkg::C_IDX, PAIR = 1 << ctpm_pkg::C_PAIR;

	ctpm_core uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .sig_a(sig_a), .sig_b(sig_b),
		.sig_z(sig_z), .samp_clk(samp_clk), .pair_in(pair_in), .pair_out(pair_out),
		.smp_valid(smp_valid), .smp_ready(smp_ready), .smp(smp));
	ctpm_src src (.aclk(aclk), .sig_a(sig_a), .sig_b(sig_b), .sig_z(sig_z),
		.samp_clk(samp_clk), .pair_in(pair_in));

	always #20 aclk = ~aclk;

	// log every sample the stream hands over
	always @(posedge aclk)
		if (smp_valid === 1'b1 && smp_ready)
			q.push_back(smp);

	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk

	task automatic rng(input logic [31:0] g, input int e, input string m);
		chk(g >= 32'(e - 1) && g <= 32'(e + 1), m);
	endtask : rng

	// nth sample from the end; all ones when the log is short
	function automatic ctpm_pkg::ctpm_smp_s lastd(input int k);
		return (q.size() >= k) ? q[q.size() - k] : '1;
	endfunction : lastd

	// write: both channels offered at once, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		wstrb <= strb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 40);
		resp = bresp;
		bready <= 1'b0;
		@(posedge aclk);
		chk(n < 40, "write hang");
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 40);
		rv = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge aclk);
		chk(n < 40, "read hang");
	endtask : rd

	function automatic logic [31:0] cw(input int mode, input int ex);
		return (32'(mode) << ctpm_pkg::C_MODE) | 32'(ex);
	endfunction : cw

	// disarm, arm a mode with the timebase chosen up front, clear the log
	task automatic tm(input int mode, input int ex);
		wr(ctpm_pkg::A_CTRL, 32'h0);
		wr(ctpm_pkg::A_CTRL, cw(mode, ex | ARM));
		q.delete();
	endtask : tm

	task automatic t_regs;
		rd(ctpm_pkg::A_CTRL);
		chk(rv === 32'h0, "ctrl reset");
		rd(ctpm_pkg::A_STAT);
		chk(rv === 32'h0, "stat reset");
		wr(ctpm_pkg::A_INIT, 32'h11223344);
		strb = 4'h3;
		wr(ctpm_pkg::A_INIT, 32'hAAAA5555);
		strb = 4'hF;
		rd(ctpm_pkg::A_INIT);
		chk(rv === 32'h11225555, "strobe merge");
		wr(ctpm_pkg::A_RES, 32'hFFFFFFFF);
		rd(ctpm_pkg::A_RES);
		chk(rv === 32'h0, "result is read only");
		rd(8'h18);
		chk(resp === ctpm_pkg::R_ERR && rv === 32'h0, "unmapped read");
		wr(8'h18, 32'h1);
		chk(resp === ctpm_pkg::R_ERR, "unmapped write");
	endtask : t_regs

	task automatic t_period;
		for (int p = 0; p < 2; p++) begin
			tm(ctpm_pkg::M_PERIOD, p << ctpm_pkg::C_POL);
			src.sq(25, 25, 3, 1'b0);
			src.w(8);
			chk(q.size() == 3, "period count");
			chk(lastd(3).data < 32'd38, "first sample");
			rng(lastd(1).data, 40, "period fast");
		end
		tm(ctpm_pkg::M_PERIOD, TB);
		src.sq(250, 250, 2, 1'b0);
		src.w(8);
		rng(lastd(1).data, 2, "period slow");
		tm(ctpm_pkg::M_PERIOD, PAIR);
		src.sq(25, 25, 3, 1'b1);
		src.w(8);
		rng(lastd(1).data, 40, "paired period");
		fork
			src.pulse(0, 10);
			begin
				src.w(6);
				chk(pair_out === 1'b1, "pair out");
			end
		join
	endtask : t_period

	task automatic t_width;
		for (int p = 0; p < 2; p++) begin
			tm(ctpm_pkg::M_PULSE, p << ctpm_pkg::C_POL);
			src.sq(30, 20, 2, 1'b0);
			src.w(8);
			rng(lastd(1).data, p ? 16 : 24, "width");
			tm(ctpm_pkg::M_TWO_EDGE, p << ctpm_pkg::C_POL2);
			src.e2();
			rng(lastd(1).data, p ? 28 : 20, "two edge");
		end
		tm(ctpm_pkg::M_SEMI, 0);
		src.sq(30, 20, 2, 1'b0);
		src.w(8);
		chk(lastd(1).semi_hi === 1'b1 && lastd(2).semi_hi === 1'b0, "semi order");
		rng(lastd(1).data, 24, "semi high");
		rng(lastd(2).data, 16, "semi low");
		rd(ctpm_pkg::A_STAT);
		chk(rv[ctpm_pkg::S_SEMI] === 1'b1 && rv[ctpm_pkg::S_RES] === 1'b1, "semi stat");
		chk(rv[ctpm_pkg::S_ARM] === 1'b1 && rv[ctpm_pkg::S_ROLL] === 1'b0, "arm stat");
		rd(ctpm_pkg::A_RES);
		rng(rv, 24, "result register");
		rd(ctpm_pkg::A_STAT);
		chk(rv[ctpm_pkg::S_RES] === 1'b0, "result read clears");
	endtask : t_width

	// all decoders; reverse steps must count down
	task automatic t_pos;
		wr(ctpm_pkg::A_INIT, 32'd100);
		for (int d = 0; d < 3; d++) begin
			tm(ctpm_pkg::M_POSITION, d << ctpm_pkg::C_DEC);
			src.quad(5, 1'b1, 6);
			src.quad(1, 1'b0, 6);
			src.w(6);
			rd(ctpm_pkg::A_POS);
			chk(rv === 32'(100 + (4 << d)), "decode");
			rd(ctpm_pkg::A_POS);
			chk(rv === 32'(100 + (4 << d)), "read again");
		end
		tm(ctpm_pkg::M_POSITION, 3 << ctpm_pkg::C_DEC);
		repeat (3) src.pulse(0, 6);
		src.pulse(1, 6);
		rd(ctpm_pkg::A_POS);
		chk(rv === 32'd102, "two pulse");
		wr(ctpm_pkg::A_CTRL, cw(ctpm_pkg::M_POSITION, 0));
		src.quad(3, 1'b1, 6);
		rd(ctpm_pkg::A_POS);
		chk(rv === 32'd100, "unarmed read");
	endtask : t_pos

	// index off, on in phase, on out of phase
	task automatic t_index;
		int ex[3] = '{0, IDX, IDX | (1 << ctpm_pkg::C_PH)};
		int ev[3] = '{103, 7, 103};
		wr(ctpm_pkg::A_RLD, 32'd7);
		for (int k = 0; k < 3; k++) begin
			tm(ctpm_pkg::M_POSITION, ex[k]);
			src.quad(3, 1'b1, 6);
			src.pulse(2, 6);
			rd(ctpm_pkg::A_POS);
			chk(rv === 32'(ev[k]), "index reload");
		end
		tm(ctpm_pkg::M_POSITION, 1 << ctpm_pkg::C_BUF);
		src.quad(2, 1'b1, 6);
		src.pulse(3, 6);
		src.w(4);
		chk(q.size() == 1 && lastd(1).data === 32'd102, "sampled position");
	endtask : t_index

	// stall the stream so later samples are refused
	task automatic t_stall;
		smp_ready <= 1'b0;
		tm(ctpm_pkg::M_PERIOD, 0);
		src.sq(10, 10, 3, 1'b0);
		src.w(8);
		rd(ctpm_pkg::A_STAT);
		chk(rv[ctpm_pkg::S_OVR] === 1'b1 && smp_valid === 1'b1, "overrun");
		smp_ready <= 1'b1;
		wr(ctpm_pkg::A_STAT, 32'(1 << ctpm_pkg::S_OVR));
		rd(ctpm_pkg::A_STAT);
		chk(rv[ctpm_pkg::S_OVR] === 1'b0 && q.size() == 1, "drain");
	endtask : t_stall

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	// main sequence
	initial begin
		// bus idle and reset asserted from time zero
		{aresetn, awvalid, wvalid, bready, arvalid, rready} <= 6'h00;
		{awaddr, araddr, wstrb, smp_ready} <= {16'h0000, 4'hF, 1'b1};
		wdata <= 32'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_period();
		t_width();
		t_pos();
		t_index();
		t_stall();
		wrap_up();
	end

	// watchdog well beyond the expected run
	initial begin
		#2_000_000;
		err_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		wrap_up();
	end
endmodule : test_counter_time_and_position_measure
